// >>> design/tio_top.sv
`timescale 1ns/1ns
module tio_top #(
   parameter int unsigned DEB_CYC = tio_pkg::DEB_CYC,
   parameter int unsigned PULSE_CYC = tio_pkg::TRIG_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tio_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Front-panel keys, high while pressed
   input wire logic key_onoff,
   input wire logic key_trig,
   // Trigger terminal pair, high while shorted or driven
   input wire logic trig_i,
   output logic trig_o,
   output logic trig_oe,
   // Inhibit terminal pair, high while shorted
   input wire logic inh_short,
   // Power stage control
   output logic out_en,
   output logic bleeder_on,
   output logic trig_event,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int unsigned PIN_ONOFF = 0;
   localparam int unsigned PIN_KTRIG = 1;
   localparam int unsigned PIN_TRIG = 2;
   localparam int unsigned PIN_INH = 3;
   localparam int unsigned TW = tio_pkg::TRIG_CNT_W;

   tio_pkg::tio_ctrl_t ctrl_q;
   tio_pkg::tio_st_t st_q, st_d;
   tio_pkg::tio_status_t status;
   logic [tio_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
   logic [TW-1:0] trig_cnt_q;
   logic out_on_q, out_on_d;
   logic out_en_q, bleeder_q, trig_oe_q, trig_event_q, irq_q;
   logic pulse_raw, trig_o_q;
   logic inh_true_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [3:0] pin_lvl, pin_rise;

   // ------------------------------------------------------------
   // Input conditioning
   // ------------------------------------------------------------
   tio_deb #(
      .WIDTH(4),
      .CYC(DEB_CYC)
   ) u_deb (
      .clk(clk),
      .resetn(resetn),
      .raw({inh_short, trig_i, key_trig, key_onoff}),
      .level(pin_lvl),
      .rise(pin_rise)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Zero-extend an interrupt field to the bus width
   function automatic logic [31:0] zext_irq(input logic [tio_pkg::IRQ_W-1:0] v);
      return {{(32 - tio_pkg::IRQ_W){1'b0}}, v};
   endfunction

   // Interrupt field of a write word
   function automatic logic [tio_pkg::IRQ_W-1:0] irq_bits(input logic [31:0] d);
      return d[tio_pkg::IRQ_W-1:0];
   endfunction

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire access = psel & penable & ~pready_q;
   wire done = psel & penable & pready_q;
   wire wr_done = done & pwrite;
   wire sel_ctrl = (paddr == tio_pkg::ADDR_CTRL);
   wire sel_cmd = (paddr == tio_pkg::ADDR_CMD);
   wire sel_status = (paddr == tio_pkg::ADDR_STATUS);
   wire sel_istat = (paddr == tio_pkg::ADDR_IRQ_STAT);
   wire sel_imask = (paddr == tio_pkg::ADDR_IRQ_MASK);
   wire sel_tcnt = (paddr == tio_pkg::ADDR_TRIG_CNT);
   wire hit = sel_ctrl | sel_cmd | sel_status | sel_istat | sel_imask | sel_tcnt;

   wire wr_ctrl = wr_done & sel_ctrl;
   wire wr_cmd = wr_done & sel_cmd;
   wire wr_istat = wr_done & sel_istat;
   wire wr_imask = wr_done & sel_imask;

   wire cmd_bus_trig = wr_cmd & pwdata[tio_pkg::CMD_BUS_TRIG];
   wire cmd_prot_clear = wr_cmd & pwdata[tio_pkg::CMD_PROT_CLEAR];
   wire cmd_out_on = wr_cmd & pwdata[tio_pkg::CMD_OUT_ON];
   wire cmd_out_off = wr_cmd & pwdata[tio_pkg::CMD_OUT_OFF];
   wire [tio_pkg::IRQ_W-1:0] wr_irq = irq_bits(pwdata);

   wire [31:0] rd_mux =
      sel_ctrl ? 32'(ctrl_q) :
      sel_status ? 32'(status) :
      sel_istat ? zext_irq(irq_stat_q) :
      sel_imask ? zext_irq(irq_mask_q) :
      sel_tcnt ? {{(32 - TW){1'b0}}, trig_cnt_q} :
      32'h0000_0000;

   // ------------------------------------------------------------
   // APB response, one wait state
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= access;
         pslverr_q <= access & ~hit;
         if (access & ~pwrite)
            prdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_q <= tio_pkg::CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= pwdata & tio_pkg::CTRL_WMASK;
   end

   wire dir_out = ctrl_q.trig_dir_out;
   wire src_key = (ctrl_q.trig_src == tio_pkg::TIO_SRC_KEYPAD);
   wire src_bus = (ctrl_q.trig_src == tio_pkg::TIO_SRC_BUS);
   wire src_ext = (ctrl_q.trig_src == tio_pkg::TIO_SRC_EXT);
   wire mode_level = (ctrl_q.inh_mode == tio_pkg::TIO_INH_LEVEL);
   wire mode_latch = (ctrl_q.inh_mode == tio_pkg::TIO_INH_LATCH);
   wire mode_active = mode_level | mode_latch;

   // ------------------------------------------------------------
   // Trigger path
   // ------------------------------------------------------------
   wire trig_from_key = src_key & pin_rise[PIN_KTRIG];
   wire trig_from_bus = src_bus & cmd_bus_trig;
   wire trig_from_ext = src_ext & ~dir_out & pin_rise[PIN_TRIG];
   wire trig_any = trig_from_key | trig_from_bus | trig_from_ext;
   wire pulse_start = dir_out & (trig_from_key | trig_from_bus);

   tio_pulse #(
      .CYC(PULSE_CYC)
   ) u_pulse (
      .clk(clk),
      .resetn(resetn),
      .start(pulse_start),
      .pulse(pulse_raw)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         trig_oe_q <= 1'b0;
         trig_event_q <= 1'b0;
         trig_cnt_q <= '0;
      end
      else
      begin
         trig_oe_q <= dir_out;
         trig_event_q <= trig_any;
         if (trig_any)
            trig_cnt_q <= trig_cnt_q + TW'(1);
      end
   end

   // ------------------------------------------------------------
   // Trigger drive, silenced at once when the pair turns to input
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         trig_o_q <= 1'b0;
      else
         trig_o_q <= pulse_raw & dir_out;
   end

   // ------------------------------------------------------------
   // Inhibit interpretation and latch
   // ------------------------------------------------------------
   wire inh_true = pin_lvl[PIN_INH] ^ ctrl_q.inh_invert;
   wire inh_rise = inh_true & ~inh_true_q;
   wire latch_set = mode_latch & inh_rise;
   wire latch_clr = cmd_prot_clear & ~inh_true;
   wire latched = (st_q == tio_pkg::TIO_ST_LATCHED);

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         tio_pkg::TIO_ST_CLEAR:
         begin
            if (latch_set)
               st_d = tio_pkg::TIO_ST_LATCHED;
         end
         tio_pkg::TIO_ST_LATCHED:
         begin
            if (latch_clr & ~latch_set)
               st_d = tio_pkg::TIO_ST_CLEAR;
         end
         default:
            st_d = tio_pkg::TIO_ST_CLEAR;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= tio_pkg::TIO_ST_CLEAR;
         inh_true_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         inh_true_q <= inh_true;
      end
   end

   // ------------------------------------------------------------
   // Output enable
   // ------------------------------------------------------------
   wire level_block = mode_level & inh_true;
   wire latch_block = mode_latch & latched;
   wire key_ok = ~level_block & ~latch_block;
   wire force_off = latch_set;

   always_comb
   begin
      out_on_d = out_on_q;
      if (force_off)
         out_on_d = 1'b0;
      else if (key_ok & pin_rise[PIN_ONOFF])
         out_on_d = ~out_on_q;
      else if (key_ok & cmd_out_on)
         out_on_d = 1'b1;
      else if (cmd_out_off)
         out_on_d = 1'b0;
   end

   wire out_en_d = out_on_d & key_ok & ~force_off;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         out_on_q <= 1'b0;
         out_en_q <= 1'b0;
         bleeder_q <= 1'b0;
      end
      else
      begin
         out_on_q <= out_on_d;
         out_en_q <= out_en_d;
         bleeder_q <= ctrl_q.bleed_en & ~out_en_d;
      end
   end

   // ------------------------------------------------------------
   // Status and interrupt
   // ------------------------------------------------------------
   always_comb
   begin
      status = '0;
      status.out_en = out_en_q;
      status.latched_disable_flag = latched;
      status.inhibit_true = inh_true;
      status.trig_in_lvl = pin_lvl[PIN_TRIG];
      status.bleeder_on = bleeder_q;
   end

   wire [tio_pkg::IRQ_W-1:0] irq_set = {mode_active & inh_rise, latch_set, trig_any};
   wire [tio_pkg::IRQ_W-1:0] irq_clr = wr_istat ? wr_irq : '0;

   assign irq_stat_d = tio_pkg::tio_w1c(irq_stat_q, irq_set, irq_clr);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= tio_pkg::IRQ_MASK_RST;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         if (wr_imask)
            irq_mask_q <= wr_irq;
         irq_q <= |(irq_stat_d & (wr_imask ? wr_irq : irq_mask_q));
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign trig_o = trig_o_q;
   assign trig_oe = trig_oe_q;
   assign out_en = out_en_q;
   assign bleeder_on = bleeder_q;
   assign trig_event = trig_event_q;
   assign irq = irq_q;

endmodule

// >>> design/tio_pkg.sv
package tio_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned DEB_TIME_US = 100;
   localparam int unsigned DEB_CYC = (DEB_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned TRIG_PULSE_US = 10;
   localparam int unsigned TRIG_PULSE_CYC = (TRIG_PULSE_US * CLK_KHZ + 999) / 1000;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_TRIG_CNT = 8'h14;

   localparam logic [31:0] CTRL_RST = 32'h0000_0009;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_007f;

   localparam int unsigned CMD_BUS_TRIG = 0;
   localparam int unsigned CMD_PROT_CLEAR = 1;
   localparam int unsigned CMD_OUT_ON = 2;
   localparam int unsigned CMD_OUT_OFF = 3;

   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_TRIG = 0;
   localparam int unsigned IRQ_LATCH = 1;
   localparam int unsigned IRQ_INH = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   localparam int unsigned TRIG_CNT_W = 16;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TIO_SRC_KEYPAD = 2'b00,
      TIO_SRC_BUS = 2'b01,
      TIO_SRC_EXT = 2'b10,
      TIO_SRC_NONE = 2'b11
   } tio_src_t;

   typedef enum logic [1:0] {
      TIO_INH_OFF = 2'b00,
      TIO_INH_LEVEL = 2'b01,
      TIO_INH_LATCH = 2'b10,
      TIO_INH_RSVD = 2'b11
   } tio_inh_t;

   typedef enum logic {
      TIO_ST_CLEAR = 1'b0,
      TIO_ST_LATCHED = 1'b1
   } tio_st_t;

   typedef struct packed {
      logic [24:0] rsvd;
      logic inh_invert;
      tio_inh_t inh_mode;
      logic bleed_en;
      tio_src_t trig_src;
      logic trig_dir_out;
   } tio_ctrl_t;

   typedef struct packed {
      logic [26:0] rsvd;
      logic bleeder_on;
      logic trig_in_lvl;
      logic inhibit_true;
      logic latched_disable_flag;
      logic out_en;
   } tio_status_t;

   // Sticky flag update, set wins over clear
   function automatic logic [IRQ_W-1:0] tio_w1c(
      input logic [IRQ_W-1:0] old,
      input logic [IRQ_W-1:0] set,
      input logic [IRQ_W-1:0] clr
   );
      return set | (old & ~clr);
   endfunction

endpackage

// >>> design/tio_deb.sv
`timescale 1ns/1ns
module tio_deb #(
   parameter int unsigned WIDTH = 4,
   parameter int unsigned CYC = 2500
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Raw pins and filtered result
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   localparam int unsigned CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] CYC_C = CW'(CYC);

   logic [WIDTH-1:0] s1_q, s2_q, s3_q;
   logic [WIDTH-1:0] level_q, rise_q;
   logic [CW-1:0] cnt_q [WIDTH];

   // ------------------------------------------------------------
   // Three-stage synchroniser, then a stability filter
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      wire agree = (s2_q[i] == s3_q[i]);
      wire differs = agree & (s3_q[i] != level_q[i]);
      always_ff @(posedge clk or negedge resetn)
      begin
         if (!resetn)
         begin
            cnt_q[i] <= '0;
            level_q[i] <= 1'b0;
            rise_q[i] <= 1'b0;
         end
         else
         begin
            rise_q[i] <= 1'b0;
            if (!differs)
               cnt_q[i] <= '0;
            else if (cnt_q[i] >= CYC_C - CW'(1))
            begin
               cnt_q[i] <= '0;
               level_q[i] <= s3_q[i];
               rise_q[i] <= s3_q[i];
            end
            else
               cnt_q[i] <= cnt_q[i] + CW'(1);
         end
      end
   end

   assign level = level_q;
   assign rise = rise_q;

endmodule

// >>> design/tio_pulse.sv
`timescale 1ns/1ns
module tio_pulse #(
   parameter int unsigned CYC = 250
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Start strobe and stretched pulse
   input wire logic start,
   output logic pulse
);

   localparam int unsigned CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] CYC_C = CW'(CYC);

   logic [CW-1:0] cnt_q;
   logic pulse_q;

   // ------------------------------------------------------------
   // Retriggerable high pulse of CYC cycles
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end
      else if (start)
      begin
         cnt_q <= CYC_C - CW'(1);
         pulse_q <= 1'b1;
      end
      else if (cnt_q != '0)
         cnt_q <= cnt_q - CW'(1);
      else
         pulse_q <= 1'b0;
   end

   assign pulse = pulse_q;

endmodule

// >>> dv/tio_checker.sv
`timescale 1ns/1ns
module tio_checker #(
   parameter int unsigned DEB_CYC = 4,
   parameter int unsigned PULSE_CYC = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tio_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Keys and terminals
   input wire logic key_onoff,
   input wire logic key_trig,
   input wire logic trig_i,
   input wire logic trig_o,
   input wire logic trig_oe,
   input wire logic inh_short,
   // Power stage and interrupt
   input wire logic out_en,
   input wire logic bleeder_on,
   input wire logic trig_event,
   input wire logic irq
);
   // Inhibit must be settled past sync and debounce
   localparam int SETTLE = DEB_CYC + 8;
   logic [6:0] ctrl_q;
   logic [15:0] run_q;
   int inh_cnt_q;
   wire wr_ctrl = psel && penable && pready && pwrite && paddr == tio_pkg::ADDR_CTRL;
   wire inh_true = inh_short ^ ctrl_q[6];
   wire inh_gate = ctrl_q[5:4] == 2'b01 || ctrl_q[5:4] == 2'b10;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= tio_pkg::CTRL_RST[6:0];
         run_q <= 16'h0000;
         inh_cnt_q <= 0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= pwdata[6:0];
         run_q <= trig_o ? run_q + 16'h0001 : 16'h0000;
         inh_cnt_q <= (!inh_true || wr_ctrl) ? 0 : (inh_cnt_q < SETTLE ? inh_cnt_q + 1 : inh_cnt_q);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   AST_APB_ANSWER: assert property (s_access |=> s_answer)
      else $error("apb answer not one cycle after access");
   AST_APB_ERR: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   AST_BLEED_OFF: assert property (!ctrl_q[3] |=> !bleeder_on)
      else $error("bleeder on while disabled");
   AST_BLEED_ON: assert property (ctrl_q[3] && !out_en |-> ##[0:1] bleeder_on)
      else $error("bleeder not on with output off");
   AST_BLEED_RUN: assert property (out_en |-> ##[0:1] !bleeder_on)
      else $error("bleeder on with output on");
   AST_TRIG_OUT: assert property (trig_event && trig_oe |-> ##[0:1] trig_o)
      else $error("trigger without output pulse");
   AST_TRIG_WIDTH: assert property ($fell(trig_o) |-> run_q >= PULSE_CYC)
      else $error("trigger pulse too short");
   AST_TRIG_QUIET: assert property (!trig_oe && !$past(trig_oe) |-> !trig_o)
      else $error("trigger driven in input direction");
   AST_TRIG_EXT: assert property (trig_event && !trig_oe && ctrl_q[2:1] == 2'b10 |-> trig_i)
      else $error("external trigger without short");
   AST_TRIG_ONE: assert property (trig_event |=> !trig_event)
      else $error("trigger event longer than one cycle");
   AST_INH_HOLD: assert property (inh_gate && inh_cnt_q == SETTLE |-> !out_en)
      else $error("output on while inhibit true");
endmodule

bind tio_top tio_checker #(.DEB_CYC(DEB_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_onoff(key_onoff),
   .key_trig(key_trig), .trig_i(trig_i), .trig_o(trig_o), .trig_oe(trig_oe), .inh_short(inh_short),
   .out_en(out_en), .bleeder_on(bleeder_on), .trig_event(trig_event), .irq(irq));

// >>> dv/tio_fixture.sv
`timescale 1ns/1ns
module tio_fixture (
   // Clock
   input wire logic clk,
   // Trigger terminal pair
   input wire logic trig_o,
   input wire logic trig_oe,
   output logic trig_short,
   // Inhibit contact
   output logic inh_short
);
   int pulses = 0;
   logic last_q = 1'b0;
   initial
   begin
      trig_short = 1'b0;
      inh_short = 1'b0;
   end
   // Count high pulses driven by the device
   always @(posedge clk)
   begin
      if (trig_oe && trig_o && !last_q)
         pulses++;
      last_q <= trig_o;
   end
   task automatic close_trig(input int n);
      @(posedge clk);
      trig_short <= 1'b1;
      repeat (n) @(posedge clk);
      trig_short <= 1'b0;
   endtask
   task automatic set_inh(input logic v);
      @(posedge clk);
      inh_short <= v;
   endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int unsigned DEB = 4;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, key_onoff, key_trig;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, trig_o, trig_oe, out_en, bleeder_on, trig_event, irq, trig_short, inh_short;
   wire trig_i = trig_oe ? trig_o : trig_short;
   int mismatches = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   tio_top #(.DEB_CYC(DEB), .PULSE_CYC(3)) DUT (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_onoff(key_onoff),
      .key_trig(key_trig), .trig_i(trig_i), .trig_o(trig_o), .trig_oe(trig_oe), .inh_short(inh_short),
      .out_en(out_en), .bleeder_on(bleeder_on), .trig_event(trig_event), .irq(irq));
   tio_fixture FIX (.clk(clk), .trig_o(trig_o), .trig_oe(trig_oe), .trig_short(trig_short),
      .inh_short(inh_short));
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   task automatic settle;
      repeat (DEB + 12) @(posedge clk);
   endtask
   task automatic press(input logic trig);
      @(posedge clk);
      if (trig)
         key_trig <= 1'b1;
      else
         key_onoff <= 1'b1;
      settle();
      key_trig <= 1'b0;
      key_onoff <= 1'b0;
      settle();
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      key_onoff <= 1'b0;
      key_trig <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rdc("ctrl", tio_pkg::ADDR_CTRL, tio_pkg::CTRL_RST);
      rdc("irq_mask", tio_pkg::ADDR_IRQ_MASK, 32'h0);
      chk("bleeder", 32'h1, bleeder_on);
      chk("trig_oe", 32'h1, trig_oe);
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", 32'h1, err);
      $display("test reset done");
      wr(tio_pkg::ADDR_IRQ_MASK, 32'h1);
      wr(tio_pkg::ADDR_CTRL, 32'h0b);
      wr(tio_pkg::ADDR_CMD, 32'h1);
      settle();
      chk("pulses", 32'h1, FIX.pulses);
      chk("irq", 32'h1, irq);
      rdc("trig_cnt", tio_pkg::ADDR_TRIG_CNT, 32'h1);
      wr(tio_pkg::ADDR_IRQ_STAT, 32'h1);
      settle();
      chk("irq", 32'h0, irq);
      wr(tio_pkg::ADDR_CTRL, 32'h09);
      press(1'b1);
      chk("pulses", 32'h2, FIX.pulses);
      wr(tio_pkg::ADDR_CMD, 32'h1);
      settle();
      chk("pulses", 32'h2, FIX.pulses);
      $display("test trigger out done");
      wr(tio_pkg::ADDR_CTRL, 32'h0c);
      FIX.close_trig(DEB + 12);
      settle();
      rdc("trig_cnt", tio_pkg::ADDR_TRIG_CNT, 32'h3);
      press(1'b1);
      rdc("trig_cnt", tio_pkg::ADDR_TRIG_CNT, 32'h3);
      chk("pulses", 32'h2, FIX.pulses);
      $display("test trigger in done");
      wr(tio_pkg::ADDR_CMD, 32'h4);
      settle();
      chk("bleeder", 32'h0, bleeder_on);
      wr(tio_pkg::ADDR_CMD, 32'h8);
      settle();
      chk("bleeder", 32'h1, bleeder_on);
      wr(tio_pkg::ADDR_CTRL, 32'h04);
      wr(tio_pkg::ADDR_CMD, 32'h4);
      wr(tio_pkg::ADDR_CMD, 32'h8);
      settle();
      chk("bleeder", 32'h0, bleeder_on);
      $display("test bleeder done");
      wr(tio_pkg::ADDR_CTRL, 32'h08);
      wr(tio_pkg::ADDR_CMD, 32'h4);
      FIX.set_inh(1'b1);
      settle();
      chk("out_en", 32'h1, out_en);
      FIX.set_inh(1'b0);
      settle();
      wr(tio_pkg::ADDR_CTRL, 32'h18);
      FIX.set_inh(1'b1);
      settle();
      chk("out_en", 32'h0, out_en);
      press(1'b0);
      chk("out_en", 32'h0, out_en);
      FIX.set_inh(1'b0);
      settle();
      chk("out_en", 32'h1, out_en);
      press(1'b0);
      chk("out_en", 32'h0, out_en);
      press(1'b0);
      chk("out_en", 32'h1, out_en);
      wr(tio_pkg::ADDR_CTRL, 32'h58);
      settle();
      chk("out_en", 32'h0, out_en);
      FIX.set_inh(1'b1);
      settle();
      chk("out_en", 32'h1, out_en);
      $display("test level done");
      FIX.set_inh(1'b0);
      settle();
      wr(tio_pkg::ADDR_CTRL, 32'h28);
      wr(tio_pkg::ADDR_CMD, 32'h4);
      wr(tio_pkg::ADDR_IRQ_STAT, 32'h7);
      settle();
      chk("out_en", 32'h1, out_en);
      FIX.set_inh(1'b1);
      settle();
      chk("out_en", 32'h0, out_en);
      apb(1'b0, tio_pkg::ADDR_STATUS, 32'h0);
      chk("latched", 32'h1, rd[1]);
      rdc("irq_stat", tio_pkg::ADDR_IRQ_STAT, 32'h6);
      chk("irq", 32'h0, irq);
      wr(tio_pkg::ADDR_CMD, 32'h2);
      apb(1'b0, tio_pkg::ADDR_STATUS, 32'h0);
      chk("latched", 32'h1, rd[1]);
      FIX.set_inh(1'b0);
      settle();
      chk("out_en", 32'h0, out_en);
      wr(tio_pkg::ADDR_CMD, 32'h2);
      apb(1'b0, tio_pkg::ADDR_STATUS, 32'h0);
      chk("latched", 32'h0, rd[1]);
      wr(tio_pkg::ADDR_CMD, 32'h4);
      settle();
      chk("out_en", 32'h1, out_en);
      $display("test latch done");
      test_done();
   end
endmodule
